// ==== design/pbcafm_pkg.sv ====
// Constants shared by the Port B / Port C alternate-function mux.
// Assumes pins are packed as {C7, C6, B7..B0} in every 10-bit pin vector.
package pbcafm_pkg;
    localparam int unsigned NUM_PINS  = 10;
    localparam int unsigned NUM_PORTB = 8;
    localparam int unsigned PIN_B0    = 0;
    localparam int unsigned PIN_B1    = 1;
    localparam int unsigned PIN_B2    = 2;
    localparam int unsigned PIN_B3    = 3;
    localparam int unsigned PIN_B4    = 4;
    localparam int unsigned PIN_B5    = 5;
    localparam int unsigned PIN_B6    = 6;
    localparam int unsigned PIN_B7    = 7;
    localparam int unsigned PIN_C6    = 8;
    localparam int unsigned PIN_C7    = 9;

    // Reset values of the registered pad-side outputs (per pin) and of the peripheral-side inputs
    localparam logic PAD_OUT_RST   = 1'h0;
    localparam logic PAD_OE_N_RST  = 1'h1;
    localparam logic PULLUP_RST    = 1'h0;
    localparam logic DIN_EN_RST    = 1'h0;
    localparam logic PERIPH_IN_RST = 1'h0;
    // Slave select idles high so a reset never looks like a selected slave
    localparam logic SLAVE_SEL_RST = 1'h1;
endpackage

// ==== design/pbcafm_pin_ovr.sv ====
// Generic per-pin override stage: merges override enables and values with
// the ordinary direction and output bits. Same clock as the port registers.
`timescale 1ns/1ns
module pbcafm_pin_ovr
    import pbcafm_pkg::*;
#(
    parameter int unsigned WIDTH = NUM_PINS
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] dirBit,
    input  wire logic [WIDTH-1:0] outBit,
    input  wire logic             globalPullupDisable,
    input  wire logic             sleepDinDisable,
    input  wire logic [WIDTH-1:0] pullupOvrEn,
    input  wire logic [WIDTH-1:0] pullupOvrVal,
    input  wire logic [WIDTH-1:0] dirOvrEn,
    input  wire logic [WIDTH-1:0] dirOvrVal,
    input  wire logic [WIDTH-1:0] valueOvrEn,
    input  wire logic [WIDTH-1:0] valueOvrVal,
    input  wire logic [WIDTH-1:0] dinEnableOvrEn,
    input  wire logic [WIDTH-1:0] dinEnableOvrVal,
    output logic      [WIDTH-1:0] dinEnableNxt,
    output logic      [WIDTH-1:0] padOut,
    output logic      [WIDTH-1:0] padOeN,
    output logic      [WIDTH-1:0] pullupEn,
    output logic      [WIDTH-1:0] dinEnable
);
    logic [WIDTH-1:0] drive;
    logic [WIDTH-1:0] padOut_nxt;
    logic [WIDTH-1:0] pullup_nxt;
    logic [WIDTH-1:0] padOut_r;
    logic [WIDTH-1:0] padOeN_r;
    logic [WIDTH-1:0] pullup_r;
    logic [WIDTH-1:0] dinEn_r;

    assign drive        = (dirOvrEn & dirOvrVal) | (~dirOvrEn & dirBit);
    assign padOut_nxt   = (valueOvrEn & valueOvrVal) | (~valueOvrEn & outBit);
    // Global disable gates every pull-up, overridden or not
    assign pullup_nxt   = ((pullupOvrEn & pullupOvrVal)
                        | (~pullupOvrEn & ~dirBit & outBit))
                        & {WIDTH{~globalPullupDisable}};
    assign dinEnableNxt = (dinEnableOvrEn & dinEnableOvrVal)
                        | (~dinEnableOvrEn & {WIDTH{~sleepDinDisable}});

    always_ff @(posedge clk) begin
        if (srst) begin
            padOut_r <= {WIDTH{PAD_OUT_RST}};
            padOeN_r <= {WIDTH{PAD_OE_N_RST}};
            pullup_r <= {WIDTH{PULLUP_RST}};
            dinEn_r  <= {WIDTH{DIN_EN_RST}};
        end else begin
            padOut_r <= padOut_nxt;
            padOeN_r <= ~drive;
            pullup_r <= pullup_nxt;
            dinEn_r  <= dinEnableNxt;
        end
    end

    assign padOut    = padOut_r;
    assign padOeN    = padOeN_r;
    assign pullupEn  = pullup_r;
    assign dinEnable = dinEn_r;
endmodule

// ==== design/pbcafm_mux.sv ====
// Alternate-function override mux for pins B7..B0, C7 and C6.
// Peripherals and port registers share clk; pad inputs are asynchronous.
// Behaviour
// - B7 carries timer0 compare A when enabled
// - B7 carries timer1 compare C when enabled
// - B6 carries timer1 B or fast B
// - B5 carries timer1 A or complementary fast B
// - B4 carries timer2 compare A when enabled
// - Pin-change mask plus group enable forces digital input enable on
// - B3 input as master, slave data as slave
// - B2 input as slave, master data as master
// - B1 input as slave, clock out as master
// - B0 input as slave, select active low
// - Forced SPI inputs keep port-bit pull-up control
// - B3/B2 split into master and slave paths
// - Programming uses B3 output, B2 input
// - C7 outputs prescaled system clock under fuse
// - C7 feeds timer3 capture, outputs fast A
// - Global disable switches off every pull-up
`timescale 1ns/1ns
module pbcafm_mux
    import pbcafm_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [NUM_PORTB-1:0] portbDir,
    input  wire logic [NUM_PORTB-1:0] portbOut,
    input  wire logic [1:0]           portcDir,
    input  wire logic [1:0]           portcOut,
    input  wire logic                 globalPullupDisable,
    input  wire logic                 sleepDinDisable,
    input  wire logic                 timer0CmpAEn,
    input  wire logic                 timer0CmpAOut,
    input  wire logic                 timer1CmpCEn,
    input  wire logic                 timer1CmpCOut,
    input  wire logic                 timer1CmpBEn,
    input  wire logic                 timer1CmpBOut,
    input  wire logic                 timer1CmpAEn,
    input  wire logic                 timer1CmpAOut,
    input  wire logic                 timer2CmpAEn,
    input  wire logic                 timer2CmpAOut,
    input  wire logic                 fastTimerCmpBEn,
    input  wire logic                 fastTimerCmpBOut,
    input  wire logic                 fastTimerCmpBnEn,
    input  wire logic                 fastTimerCmpBnOut,
    input  wire logic                 fastTimerCmpAEn,
    input  wire logic                 fastTimerCmpAOut,
    input  wire logic                 fastTimerCmpAnEn,
    input  wire logic                 fastTimerCmpAnOut,
    input  wire logic [NUM_PORTB-1:0] pinChangeMask,
    input  wire logic                 pinChangeGroup0En,
    input  wire logic                 serialPeriphEnable,
    input  wire logic                 serialPeriphMasterSel,
    input  wire logic                 spiSlaveOut,
    input  wire logic                 spiMasterOut,
    input  wire logic                 spiClockOut,
    input  wire logic                 progModeActive,
    input  wire logic                 progSerialDataOut,
    input  wire logic                 clockOutFuse,
    input  wire logic                 prescaledClock,
    input  wire logic                 timer3CaptureEnable,
    input  wire logic [NUM_PINS-1:0]  padIn,
    output logic      [NUM_PINS-1:0]  padOut,
    output logic      [NUM_PINS-1:0]  padOeN,
    output logic      [NUM_PINS-1:0]  pullupEn,
    output logic      [NUM_PINS-1:0]  dinEnable,
    output logic      [NUM_PORTB-1:0] pinChangeSrc,
    output logic                      spiMasterIn,
    output logic                      spiSlaveIn,
    output logic                      spiClockIn,
    output logic                      spiSlaveSelN,
    output logic                      progSerialDataIn,
    output logic                      timer3CaptureIn
);
    logic [NUM_PINS-1:0]  pullupOvrEn;
    logic [NUM_PINS-1:0]  pullupOvrVal;
    logic [NUM_PINS-1:0]  dirOvrEn;
    logic [NUM_PINS-1:0]  dirOvrVal;
    logic [NUM_PINS-1:0]  valueOvrEn;
    logic [NUM_PINS-1:0]  valueOvrVal;
    logic [NUM_PINS-1:0]  dinEnableOvrEn;
    logic [NUM_PINS-1:0]  dinEnableOvrVal;
    logic [NUM_PINS-1:0]  dinEnableNxt;
    logic [NUM_PINS-1:0]  dirBit;
    logic [NUM_PINS-1:0]  outBit;
    logic [NUM_PINS-1:0]  padSync1_r;
    logic [NUM_PINS-1:0]  padSync2_r;
    logic [NUM_PINS-1:0]  padLive;
    logic [NUM_PORTB-1:0] pinChange_r;
    logic                 spiMstrIn_r;
    logic                 spiSlvIn_r;
    logic                 spiClkIn_r;
    logic                 spiSelN_r;
    logic                 progIn_r;
    logic                 capIn_r;
    logic                 spiMaster;
    logic                 spiSlave;
    logic                 noOverride;
    logic [3:0]           spiPull;

    assign dirBit    = {portcDir, portbDir};
    assign outBit    = {portcOut, portbOut};
    // Programming mode owns B3/B2 and keeps the SPI off the pins
    assign spiMaster = serialPeriphEnable & serialPeriphMasterSel & ~progModeActive;
    assign spiSlave  = serialPeriphEnable & ~serialPeriphMasterSel & ~progModeActive;
    assign spiPull   = portbOut[3:0] & {4{~globalPullupDisable}};

    // Pull-up: only SPI-forced inputs take the override, from the port bit
    assign pullupOvrEn  = {6'h00, spiMaster, spiSlave, spiSlave, spiSlave};
    assign pullupOvrVal = {6'h00, spiPull};

    // Direction overrides
    assign dirOvrEn[PIN_B0] = spiSlave;
    assign dirOvrEn[PIN_B1] = spiSlave;
    assign dirOvrEn[PIN_B2] = spiSlave | progModeActive;
    assign dirOvrEn[PIN_B3] = spiMaster | progModeActive;
    assign dirOvrEn[PIN_B7:PIN_B4] = 4'h0;
    assign dirOvrEn[PIN_C6] = 1'h0;
    assign dirOvrEn[PIN_C7] = clockOutFuse;
    // Only B3 (programming data) and C7 (clock output) are ever forced to drive; B2..B0 forced inputs
    assign dirOvrVal        = {1'h1, 5'h00, progModeActive, 3'h0};

    // Value overrides
    assign valueOvrEn[PIN_B0] = 1'h0;
    assign valueOvrEn[PIN_B1] = spiMaster;
    assign valueOvrEn[PIN_B2] = spiMaster;
    assign valueOvrEn[PIN_B3] = spiSlave | progModeActive;
    assign valueOvrEn[PIN_B4] = timer2CmpAEn;
    assign valueOvrEn[PIN_B5] = timer1CmpAEn | fastTimerCmpBnEn;
    assign valueOvrEn[PIN_B6] = timer1CmpBEn | fastTimerCmpBEn;
    assign valueOvrEn[PIN_B7] = timer0CmpAEn | timer1CmpCEn;
    assign valueOvrEn[PIN_C6] = fastTimerCmpAnEn;
    assign valueOvrEn[PIN_C7] = clockOutFuse | fastTimerCmpAEn;

    assign valueOvrVal[PIN_B0] = 1'h0;
    assign valueOvrVal[PIN_B1] = spiClockOut;
    assign valueOvrVal[PIN_B2] = spiMasterOut;
    assign valueOvrVal[PIN_B3] = progModeActive ? progSerialDataOut : spiSlaveOut;
    assign valueOvrVal[PIN_B4] = timer2CmpAOut;
    assign valueOvrVal[PIN_B5] = (timer1CmpAEn & timer1CmpAOut)
                               | (fastTimerCmpBnEn & fastTimerCmpBnOut);
    assign valueOvrVal[PIN_B6] = (timer1CmpBEn & timer1CmpBOut)
                               | (fastTimerCmpBEn & fastTimerCmpBOut);
    // Both compare units may share B7; their waveforms combine by OR
    assign valueOvrVal[PIN_B7] = (timer0CmpAEn & timer0CmpAOut)
                               | (timer1CmpCEn & timer1CmpCOut);
    assign valueOvrVal[PIN_C6] = fastTimerCmpAnOut;
    // Clock output wins over the fast PWM when the fuse is set
    assign valueOvrVal[PIN_C7] = clockOutFuse ? prescaledClock : fastTimerCmpAOut;

    assign dinEnableOvrEn  = {2'h0, pinChangeMask & {NUM_PORTB{pinChangeGroup0En}}};
    assign dinEnableOvrVal = {2'h0, {NUM_PORTB{1'h1}}};

    pbcafm_pin_ovr #(
        .WIDTH (NUM_PINS)
    ) u_pinOvr (
        .clk                 (clk),
        .srst                (srst),
        .dirBit              (dirBit),
        .outBit              (outBit),
        .globalPullupDisable (globalPullupDisable),
        .sleepDinDisable     (sleepDinDisable),
        .pullupOvrEn         (pullupOvrEn),
        .pullupOvrVal        (pullupOvrVal),
        .dirOvrEn            (dirOvrEn),
        .dirOvrVal           (dirOvrVal),
        .valueOvrEn          (valueOvrEn),
        .valueOvrVal         (valueOvrVal),
        .dinEnableOvrEn      (dinEnableOvrEn),
        .dinEnableOvrVal     (dinEnableOvrVal),
        .dinEnableNxt        (dinEnableNxt),
        .padOut              (padOut),
        .padOeN              (padOeN),
        .pullupEn            (pullupEn),
        .dinEnable           (dinEnable)
    );

    // Pads are asynchronous: two flops before anything reads them
    always_ff @(posedge clk) begin
        if (srst) begin
            padSync1_r <= {NUM_PINS{PERIPH_IN_RST}};
            padSync2_r <= {NUM_PINS{PERIPH_IN_RST}};
        end else begin
            padSync1_r <= padIn;
            padSync2_r <= padSync1_r;
        end
    end

    assign padLive = padSync2_r & dinEnableNxt;

    always_ff @(posedge clk) begin
        if (srst) begin
            pinChange_r <= {NUM_PORTB{PERIPH_IN_RST}};
            spiMstrIn_r <= PERIPH_IN_RST;
            spiSlvIn_r  <= PERIPH_IN_RST;
            spiClkIn_r  <= PERIPH_IN_RST;
            spiSelN_r   <= SLAVE_SEL_RST;
            progIn_r    <= PERIPH_IN_RST;
            capIn_r     <= PERIPH_IN_RST;
        end else begin
            pinChange_r <= padLive[NUM_PORTB-1:0];
            spiMstrIn_r <= padLive[PIN_B3];
            spiSlvIn_r  <= padLive[PIN_B2];
            spiClkIn_r  <= padLive[PIN_B1];
            spiSelN_r   <= ~spiSlave | padLive[PIN_B0];
            progIn_r    <= progModeActive & padLive[PIN_B2];
            capIn_r     <= timer3CaptureEnable & padLive[PIN_C7];
        end
    end

    assign pinChangeSrc     = pinChange_r;
    assign spiMasterIn      = spiMstrIn_r;
    assign spiSlaveIn       = spiSlvIn_r;
    assign spiClockIn       = spiClkIn_r;
    assign spiSlaveSelN     = spiSelN_r;
    assign progSerialDataIn = progIn_r;
    assign timer3CaptureIn  = capIn_r;

    assign noOverride = ~(timer0CmpAEn | timer1CmpCEn | timer1CmpBEn | timer1CmpAEn
                      | timer2CmpAEn | fastTimerCmpBEn | fastTimerCmpBnEn | fastTimerCmpAEn
                      | fastTimerCmpAnEn | serialPeriphEnable | progModeActive
                      | clockOutFuse);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence capInputHeld;
        (timer3CaptureEnable && !sleepDinDisable) [*3];
    endsequence

    b7Timer0_a: assert property (timer0CmpAEn && !timer1CmpCEn
                                 |=> padOut[PIN_B7] == $past(timer0CmpAOut))
        else $error("B7 does not follow timer0 compare A");
    b7Timer1_a: assert property (timer1CmpCEn && !timer0CmpAEn
                                 |=> padOut[PIN_B7] == $past(timer1CmpCOut))
        else $error("B7 does not follow timer1 compare C");
    b6Compare_a: assert property (timer1CmpBEn && !fastTimerCmpBEn
                                  |=> padOut[PIN_B6] == $past(timer1CmpBOut))
        else $error("B6 does not follow timer1 compare B");
    b5Compl_a: assert property (fastTimerCmpBnEn && !timer1CmpAEn
                                |=> padOut[PIN_B5] == $past(fastTimerCmpBnOut))
        else $error("B5 does not follow complementary fast compare B");
    b4Compare_a: assert property (timer2CmpAEn
                                  |=> padOut[PIN_B4] == $past(timer2CmpAOut))
        else $error("B4 does not follow timer2 compare A");
    pinChgDin_a: assert property (pinChangeGroup0En
                                  |=> (dinEnable[NUM_PORTB-1:0] & $past(pinChangeMask))
                                      == $past(pinChangeMask))
        else $error("Pin-change pin has digital input disabled");
    misoInput_a: assert property (spiMaster |=> padOeN[PIN_B3])
        else $error("B3 driven while SPI master");
    mosiInput_a: assert property (spiSlave |=> padOeN[PIN_B2]
                                  && padOeN[PIN_B1] == $past(!portbDir[PIN_B1] || spiSlave))
        else $error("B2 driven while SPI slave");
    sckInput_a: assert property (spiSlave |=> padOeN[PIN_B1])
        else $error("B1 driven while SPI slave");
    selectPin_a: assert property (spiMaster |=> padOut[PIN_B0] == $past(portbOut[PIN_B0])
                                  && padOeN[PIN_B0] == !$past(portbDir[PIN_B0]))
        else $error("B0 overridden in master mode");
    spiPullup_a: assert property (spiMaster |=> pullupEn[PIN_B3]
                                  == ($past(portbOut[PIN_B3]) && !$past(globalPullupDisable)))
        else $error("Forced B3 input lost port pull-up control");
    progOutput_a: assert property (progModeActive |=> !padOeN[PIN_B3]
                                   && padOut[PIN_B3] == $past(progSerialDataOut))
        else $error("B3 not driving programming data");
    clockOut_a: assert property (clockOutFuse |=> !padOeN[PIN_C7]
                                 && padOut[PIN_C7] == $past(prescaledClock))
        else $error("C7 not driving prescaled clock");
    captureIn_a: assert property (capInputHeld |=> timer3CaptureIn == $past(padIn[PIN_C7], 3))
        else $error("Capture input does not follow C7 pad");
    pullupOff_a: assert property (globalPullupDisable |=> pullupEn == 10'h000)
        else $error("Pull-up on while globally disabled");
    noOverride_a: assert property (noOverride |=> padOut == $past(outBit)
                                   && padOeN == ~$past(dirBit))
        else $error("Pin overridden with no function enabled");
endmodule

// ==== tb/pbcafm_periph_model.sv ====
// Stand-in for the on-chip timers, SPI and clock prescaler behind the mux.
// Assumes the same clk and srst as the mux; every waveform is a clk-domain level.
`timescale 1ns/1ns
module pbcafm_periph_model (
    input  wire logic        clk,
    input  wire logic        srst,
    output logic      [12:0] wave
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    assign cnt_nxt = cnt_r + 8'h01;
    // Bits 7..0 toggle at different rates; bits 12..8 repeat the rates of bits 4..0
    assign wave = {cnt_r[4:0], cnt_r} ^ 13'h0A5A;
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== tb/port_b_c_alt_function_mux_bench.sv ====
// Self-checking bench for the Port B / C alternate-function mux.
// Assumes the peripheral stand-in drives all waveforms; pads are driven here.
`timescale 1ns/1ns
module port_b_c_alt_function_mux_bench;
    import pbcafm_pkg::*;
    logic clk, srst, global_pullup_disable, sleep, pcGrp, serial_periph_enable, serial_periph_master_sel, prog, progOut, fuse, capEn;
    logic [9:0] dir, out, padIn, padOut, padOeN, pullupEn, dinEnable;
    logic [8:0] tEn;
    logic [12:0] wave;
    logic [7:0] pcMask, pcSrc;
    logic sMI, sSI, sCI, ssN, prog_serial_data_in, capIn, spiM, spiS;
    logic [9:0] fIn, fOut, drv, expOut, expPu, expDin;
    int fail_count = 0;
    int num_checks = 0;
    pbcafm_periph_model partner (.clk(clk), .srst(srst), .wave(wave));
    pbcafm_mux dut (.clk(clk), .srst(srst), .portbDir(dir[7:0]), .portbOut(out[7:0]),
        .portcDir(dir[9:8]), .portcOut(out[9:8]), .globalPullupDisable(global_pullup_disable),
        .sleepDinDisable(sleep), .timer0CmpAEn(tEn[0]), .timer0CmpAOut(wave[0]),
        .timer1CmpCEn(tEn[1]), .timer1CmpCOut(wave[1]), .timer1CmpBEn(tEn[2]),
        .timer1CmpBOut(wave[2]), .timer1CmpAEn(tEn[3]), .timer1CmpAOut(wave[3]),
        .timer2CmpAEn(tEn[4]), .timer2CmpAOut(wave[4]), .fastTimerCmpBEn(tEn[5]),
        .fastTimerCmpBOut(wave[5]), .fastTimerCmpBnEn(tEn[6]), .fastTimerCmpBnOut(wave[6]),
        .fastTimerCmpAEn(tEn[7]), .fastTimerCmpAOut(wave[7]), .fastTimerCmpAnEn(tEn[8]),
        .fastTimerCmpAnOut(wave[8]), .pinChangeMask(pcMask), .pinChangeGroup0En(pcGrp),
        .serialPeriphEnable(serial_periph_enable), .serialPeriphMasterSel(serial_periph_master_sel), .spiSlaveOut(wave[9]),
        .spiMasterOut(wave[10]), .spiClockOut(wave[11]), .progModeActive(prog),
        .progSerialDataOut(progOut), .clockOutFuse(fuse), .prescaledClock(wave[12]),
        .timer3CaptureEnable(capEn), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
        .pullupEn(pullupEn), .dinEnable(dinEnable), .pinChangeSrc(pcSrc),
        .spiMasterIn(sMI), .spiSlaveIn(sSI), .spiClockIn(sCI), .spiSlaveSelN(ssN),
        .progSerialDataIn(prog_serial_data_in), .timer3CaptureIn(capIn));
    // Reference view of the pad side, from the inputs seen at one edge
    always_comb begin
        spiM = serial_periph_enable & serial_periph_master_sel & ~prog;
        spiS = serial_periph_enable & ~serial_periph_master_sel & ~prog;
        fIn = {6'h00, spiM, spiS | prog, spiS, spiS};
        fOut = {fuse, 5'h00, prog, 3'h0};
        drv = (dir & ~fIn) | fOut;
        expOut = out;
        if (tEn[0] | tEn[1]) expOut[7] = (tEn[0] & wave[0]) | (tEn[1] & wave[1]);
        if (tEn[2] | tEn[5]) expOut[6] = (tEn[2] & wave[2]) | (tEn[5] & wave[5]);
        if (tEn[3] | tEn[6]) expOut[5] = (tEn[3] & wave[3]) | (tEn[6] & wave[6]);
        if (tEn[4]) expOut[4] = wave[4];
        if (prog) expOut[3] = progOut;
        else if (spiS) expOut[3] = wave[9];
        if (spiM) expOut[2] = wave[10];
        if (spiM) expOut[1] = wave[11];
        expOut[9] = fuse ? wave[12] : (tEn[7] ? wave[7] : out[9]);
        if (tEn[8]) expOut[8] = wave[8];
        expPu = (~dir | fIn) & out & {10{~global_pullup_disable}};
        expDin = {{2{~sleep}}, (pcMask & {8{pcGrp}}) | {8{~sleep}}};
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [9:0] got, input logic [9:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    // Capture the reference between edges, compare once the next edge has landed
    task automatic chk_pads(input int n);
        logic [9:0] eo, ed, ep, en, pm;
        repeat (n) begin
            @(negedge clk);
            eo = expOut;
            ed = drv;
            ep = expPu;
            en = expDin;
            pm = ~fOut;
            @(posedge clk);
            #1;
            check(padOeN, ~ed, "pad direction");
            check(padOut & ed, eo & ed, "pad value");
            check(pullupEn & pm, ep & pm, "pull-up");
            check(dinEnable, en, "input enable");
        end
    endtask
    task automatic set_idle();
        {global_pullup_disable, sleep, pcGrp, serial_periph_enable, serial_periph_master_sel, prog, progOut, fuse, capEn} = 9'h000;
        tEn = 9'h000;
        pcMask = 8'h00;
        padIn = 10'h000;
    endtask
    task automatic t_plain();
        dir = 10'h0F0;
        out = 10'h3CC;
        chk_pads(3);
        global_pullup_disable = 1'b1;
        chk_pads(3);
        $display("test plain done");
    endtask
    task automatic t_timers();
        dir = 10'h0FF;
        for (int i = 0; i < 7; i++) begin
            tEn = 9'h001 << i;
            chk_pads(4);
        end
        tEn = 9'h07F;
        chk_pads(4);
        dir = 10'h000;
        chk_pads(3);
        $display("test timers done");
    endtask
    task automatic t_spi();
        dir = 10'h00F;
        out = 10'h00F;
        serial_periph_enable = 1'b1;
        serial_periph_master_sel = 1'b1;
        padIn = 10'h008;
        chk_pads(5);
        check({7'h00, sMI, sSI, ssN}, 10'h005, "spi master inputs");
        serial_periph_master_sel = 1'b0;
        padIn = 10'h006;
        chk_pads(5);
        check({6'h00, sMI, sSI, sCI, ssN}, 10'h006, "spi slave inputs");
        padIn = 10'h001;
        global_pullup_disable = 1'b1;
        chk_pads(5);
        check({9'h000, ssN}, 10'h001, "slave deselect");
        $display("test spi done");
    endtask
    task automatic t_prog();
        {serial_periph_enable, serial_periph_master_sel, prog, progOut} = 4'hF;
        dir = 10'h000;
        padIn = 10'h004;
        chk_pads(5);
        check({9'h000, prog_serial_data_in}, 10'h001, "programming input");
        progOut = 1'b0;
        chk_pads(2);
        $display("test prog done");
    endtask
    task automatic t_portc();
        dir = 10'h000;
        out = 10'h300;
        fuse = 1'b1;
        capEn = 1'b1;
        padIn = 10'h200;
        chk_pads(5);
        check({9'h000, capIn}, 10'h001, "capture input");
        fuse = 1'b0;
        dir = 10'h300;
        tEn = 9'h180;
        chk_pads(4);
        $display("test portc done");
    endtask
    task automatic t_pinchange();
        sleep = 1'b1;
        pcMask = 8'h0F;
        pcGrp = 1'b1;
        padIn = 10'h3A5;
        chk_pads(5);
        check({2'h0, pcSrc}, 10'h005, "pin-change sources");
        pcGrp = 1'b0;
        chk_pads(5);
        check({2'h0, pcSrc}, 10'h000, "sleeping inputs");
        $display("test pinchange done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #10000;
        fail_count++;
        wrap_up();
    end
    initial begin
        srst = 1'b1;
        dir = 10'h000;
        out = 10'h000;
        set_idle();
        repeat (5) @(posedge clk);
        #1;
        check(padOeN, 10'h3FF, "reset direction");
        check({9'h000, ssN}, 10'h001, "reset select");
        srst = 1'b0;
        t_plain();
        set_idle();
        t_timers();
        set_idle();
        t_spi();
        set_idle();
        t_prog();
        set_idle();
        t_portc();
        set_idle();
        t_pinchange();
        wrap_up();
    end
endmodule
